// ---- rtl/aofr_defines.svh ----
// register offsets, field positions and reset values for the output format register bank
`ifndef AOFR_DEFINES_SVH
`define AOFR_DEFINES_SVH
`define AOFR_ADDR_W 8
`define AOFR_OFS_OFFSET_TRIM 8'h10
`define AOFR_OFS_MODE 8'h14
`define AOFR_OFS_DRIVE 8'h15
`define AOFR_OFS_PHASE 8'h16
`define AOFR_OFS_DELAY 8'h17
`define AOFR_OFS_PATT_LO 8'h19
`define AOFR_OFS_PATT_HI 8'h1a
`define AOFR_RST_OFFSET_TRIM 8'h00
`define AOFR_RST_MODE 8'h00
`define AOFR_RST_DRIVE 8'h22
`define AOFR_RST_PHASE 8'h00
`define AOFR_RST_DELAY 8'h00
`define AOFR_RST_PATT 8'h00
`define AOFR_MODE_FMT_LSB 0
`define AOFR_MODE_INV_BIT 2
`define AOFR_MODE_ODIS_BIT 4
`define AOFR_MODE_MUX_BIT 5
`define AOFR_PHASE_POL_BIT 7
`define AOFR_TEST_USER 4'h8
`define AOFR_MODE_WR_MASK 8'hf7
`define AOFR_PHASE_WR_MASK 8'h87
`define AOFR_DELAY_WR_MASK 8'ha7
`endif

// ---- rtl/aofr_pkg.sv ----
// types for the output format register bank
package aofr_pkg;
	typedef enum logic [1:0] {
		AOFR_FMT_OFFSET = 2'h0,
		AOFR_FMT_TWOS = 2'h1,
		AOFR_FMT_GRAY = 2'h2,
		AOFR_FMT_OFFSET2 = 2'h3
	} aofr_fmt_t;
endpackage

// ---- rtl/aofr_output_format.sv ----
// output format register bank with sample formatting and output clock phase selection
`timescale 1ns/1ps
`include "aofr_defines.svh"
module aofr_output_format
	import aofr_pkg::*;
#(
	parameter int DATA_W = 16
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// register port
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// converter side
	input wire logic i_smp_valid,
	input wire logic [DATA_W-1:0] i_smp_data,
	input wire logic [3:0] i_test_mode,
	input wire logic [2:0] i_clk_div_ratio,
	// output side
	output logic [DATA_W-1:0] o_out_data,
	output logic o_output_disable_bar,
	output logic o_data_output_clock,
	output logic o_mux_enable,
	output logic [7:0] o_offset_trim,
	output logic [7:0] o_drive_strength,
	output logic [7:0] o_fine_delay
);
	// elaboration check: pattern word and formats are fixed at 16 bits
	if (DATA_W != 16) begin : g_width_check
		$error("data width must be 16");
	end

	logic [7:0] trim_reg, mode_reg, drive_reg, phase_reg, delay_reg, patt_lo_reg, patt_hi_reg;
	logic [7:0] rdata_next;
	logic [DATA_W-1:0] fmt_next;
	logic [DATA_W-1:0] patt_word;
	logic [2:0] div_cnt_reg;
	logic [7:0] clk_hist_reg;
	logic base_clk;
	aofr_fmt_t fmt;

	// register writes
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			trim_reg <= `AOFR_RST_OFFSET_TRIM;
			mode_reg <= `AOFR_RST_MODE;
			drive_reg <= `AOFR_RST_DRIVE;
			phase_reg <= `AOFR_RST_PHASE;
			delay_reg <= `AOFR_RST_DELAY;
			patt_lo_reg <= `AOFR_RST_PATT;
			patt_hi_reg <= `AOFR_RST_PATT;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`AOFR_OFS_OFFSET_TRIM: trim_reg <= i_reg_wdata;
				`AOFR_OFS_MODE: mode_reg <= i_reg_wdata & `AOFR_MODE_WR_MASK;
				`AOFR_OFS_DRIVE: drive_reg <= i_reg_wdata;
				`AOFR_OFS_PHASE: phase_reg <= i_reg_wdata & `AOFR_PHASE_WR_MASK;
				`AOFR_OFS_DELAY: delay_reg <= i_reg_wdata & `AOFR_DELAY_WR_MASK;
				`AOFR_OFS_PATT_LO: patt_lo_reg <= i_reg_wdata;
				`AOFR_OFS_PATT_HI: patt_hi_reg <= i_reg_wdata;
				default: ;
			endcase
		end
	end

	// register reads, unmapped reads as zero
	always_comb begin
		case (i_reg_addr)
			`AOFR_OFS_OFFSET_TRIM: rdata_next = trim_reg;
			`AOFR_OFS_MODE: rdata_next = mode_reg;
			`AOFR_OFS_DRIVE: rdata_next = drive_reg;
			`AOFR_OFS_PHASE: rdata_next = phase_reg;
			`AOFR_OFS_DELAY: rdata_next = delay_reg;
			`AOFR_OFS_PATT_LO: rdata_next = patt_lo_reg;
			`AOFR_OFS_PATT_HI: rdata_next = patt_hi_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_reg_rdata <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				o_reg_rdata <= rdata_next;
			end
		end
	end

	assign patt_word = {patt_hi_reg, patt_lo_reg};
	assign fmt = aofr_fmt_t'(mode_reg[`AOFR_MODE_FMT_LSB +: 2]);

	// data formatting; input samples are offset binary
	always_comb begin
		fmt_next = i_smp_data;
		case (fmt)
			AOFR_FMT_TWOS: fmt_next = {~i_smp_data[DATA_W-1], i_smp_data[DATA_W-2:0]};
			AOFR_FMT_GRAY: fmt_next = i_smp_data ^ (i_smp_data >> 1);
			default: fmt_next = i_smp_data;
		endcase
		if (mode_reg[`AOFR_MODE_INV_BIT]) begin
			fmt_next = ~fmt_next;
		end
		if (i_test_mode == `AOFR_TEST_USER) begin
			fmt_next = patt_word;
		end
	end

	// data latching timing does not depend on phase settings
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_out_data <= '0;
		end else if (i_smp_valid || i_test_mode == `AOFR_TEST_USER) begin
			o_out_data <= fmt_next;
		end
	end

	// clock divider phase counter
	always_ff @(posedge i_clk_sys) begin
		if (i_srst || div_cnt_reg >= i_clk_div_ratio) begin
			div_cnt_reg <= 3'h0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 3'h1;
		end
	end

	// divided clock high for first half of the divide period
	assign base_clk = (i_clk_div_ratio == 3'h0) ? ~clk_hist_reg[0] :
		({1'b0, div_cnt_reg} <= ({1'b0, i_clk_div_ratio} >> 1));

	// history of divided clock, tap selects phase delay
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			clk_hist_reg <= 8'h00;
		end else begin
			clk_hist_reg <= {clk_hist_reg[6:0], base_clk};
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_data_output_clock <= 1'b0;
		end else begin
			o_data_output_clock <= clk_hist_reg[phase_reg[2:0]]
				^ phase_reg[`AOFR_PHASE_POL_BIT];
		end
	end

	assign o_output_disable_bar = mode_reg[`AOFR_MODE_ODIS_BIT];
	assign o_mux_enable = mode_reg[`AOFR_MODE_MUX_BIT];
	assign o_offset_trim = trim_reg;
	assign o_drive_strength = drive_reg;
	assign o_fine_delay = delay_reg;

	// checks
	// clock history is given seven cycles after reset before delay checks apply
	logic [2:0] settle_cnt;
	logic past_ok;
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			settle_cnt <= 3'h0;
		end else if (settle_cnt != 3'h7) begin
			settle_cnt <= settle_cnt + 3'h1;
		end
	end
	assign past_ok = (settle_cnt == 3'h7);

	a_fmt_twos: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		i_smp_valid && i_test_mode != `AOFR_TEST_USER && fmt == AOFR_FMT_TWOS
		&& !mode_reg[`AOFR_MODE_INV_BIT] && !i_reg_wr
		|=> o_out_data == {~$past(i_smp_data[DATA_W-1]), $past(i_smp_data[DATA_W-2:0])})
		else $error("two's complement output wrong");
	a_fmt_gray: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		i_smp_valid && i_test_mode != `AOFR_TEST_USER && fmt == AOFR_FMT_GRAY
		&& !mode_reg[`AOFR_MODE_INV_BIT] && !i_reg_wr
		|=> o_out_data == ($past(i_smp_data) ^ ($past(i_smp_data) >> 1)))
		else $error("gray output wrong");
	a_fmt_offset: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		i_smp_valid && i_test_mode != `AOFR_TEST_USER && fmt[0] == fmt[1]
		&& !mode_reg[`AOFR_MODE_INV_BIT] && !i_reg_wr
		|=> o_out_data == $past(i_smp_data))
		else $error("offset binary output wrong");
	a_phase_delay: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		past_ok && phase_reg == 8'h03 && $stable(phase_reg)
		|=> o_data_output_clock == $past(base_clk, 5))
		else $error("phase delay mismatch");
	a_phase_zero: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		past_ok && phase_reg == 8'h00 && $stable(phase_reg)
		|=> o_data_output_clock == $past(base_clk, 2))
		else $error("zero phase delay mismatch");
	a_div_phase: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		i_clk_div_ratio != 3'h0 && div_cnt_reg == 3'h0 |-> base_clk)
		else $error("divider phase wrong");
	a_div_low: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		i_clk_div_ratio != 3'h0 && div_cnt_reg == i_clk_div_ratio |-> !base_clk)
		else $error("divider last phase not low");
	a_div_wrap: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		i_clk_div_ratio != 3'h0 && div_cnt_reg == i_clk_div_ratio |=> div_cnt_reg == 3'h0)
		else $error("divider count did not wrap");
	a_latch_fixed: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		!i_smp_valid && i_test_mode != `AOFR_TEST_USER |=> $stable(o_out_data))
		else $error("data moved without sample");
	a_user_patt: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		i_test_mode == `AOFR_TEST_USER && !i_reg_wr |=> o_out_data == $past(patt_word))
		else $error("user pattern not on outputs");
	a_patt_order: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		i_reg_wr && i_reg_addr == `AOFR_OFS_PATT_HI |=> patt_word[15:8] == $past(i_reg_wdata))
		else $error("pattern high byte wrong");

	c_user: cover property (@(posedge i_clk_sys) i_test_mode == `AOFR_TEST_USER);
	c_gray: cover property (@(posedge i_clk_sys) i_smp_valid && fmt == AOFR_FMT_GRAY);
	c_phase7: cover property (@(posedge i_clk_sys) phase_reg[2:0] == 3'h7);
	c_pol: cover property (@(posedge i_clk_sys) phase_reg[`AOFR_PHASE_POL_BIT]);
	c_div: cover property (@(posedge i_clk_sys) i_clk_div_ratio == 3'h5 && div_cnt_reg == 3'h5);
endmodule // aofr_output_format

// ---- dv/aofr_capture.sv ----
// downstream capture model for formatted output words
`timescale 1ns/1ps
module aofr_capture (
	// link side
	input wire logic i_clk_out,
	input wire logic [15:0] i_word,
	// captured word
	output logic [15:0] o_cap_word
);
	always_ff @(posedge i_clk_out) begin
		o_cap_word <= i_word;
	end
endmodule // aofr_capture

// ---- dv/tb.sv ----
// self-checking testbench for the output format register bank
`timescale 1ns/1ps
module tb;
	logic clk, srst, wr, rd, sv, rv, odis, oclk, oclk_late, mux;
	logic [7:0] addr, wd, rdat, trim, drv, fdel;
	logic [15:0] sd, od, cw;
	logic [3:0] tm;
	logic [2:0] dr;
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;
	aofr_output_format aofr_output_format_inst (.i_clk_sys(clk), .i_srst(srst),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd),
		.o_reg_rdata(rdat), .o_reg_rvalid(rv), .i_smp_valid(sv), .i_smp_data(sd),
		.i_test_mode(tm), .i_clk_div_ratio(dr), .o_out_data(od),
		.o_output_disable_bar(odis), .o_data_output_clock(oclk), .o_mux_enable(mux),
		.o_offset_trim(trim), .o_drive_strength(drv), .o_fine_delay(fdel));
	// board delay so the capture edge sees settled data
	assign #5 oclk_late = oclk;
	aofr_capture aofr_capture_inst (.i_clk_out(oclk_late), .i_word(od), .o_cap_word(cw));
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 wr = 1;
		addr = a;
		wd = d;
		@(posedge clk);
		#1 wr = 0;
	endtask
	task automatic rdr(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		#1 rd = 1;
		addr = a;
		@(posedge clk);
		#1 rd = 0;
		chk("rvalid", {15'h0, rv}, 16'h1);
		chk("rdata", {8'h00, rdat}, {8'h00, e});
	endtask
	task automatic smp(input logic [15:0] d, input logic [15:0] e, input string n);
		sv = 1;
		sd = d;
		@(posedge clk);
		#1 sv = 0;
		chk(n, od, e);
	endtask
	function automatic logic [15:0] fmt(input int f, input logic [15:0] d);
		return f == 1 ? d ^ 16'h8000 : f == 2 ? d ^ (d >> 1) : d;
	endfunction
	task automatic t_regs;
		logic [7:0] a[8] = '{8'h10, 8'h14, 8'h15, 8'h16, 8'h17, 8'h19, 8'h1a, 8'h11};
		for (int i = 0; i < 8; i++) rdr(a[i], a[i] == 8'h15 ? 8'h22 : 8'h00);
		wrr(8'h14, 8'hff);
		rdr(8'h14, 8'hf7);
		chk("out_disable", {15'h0, odis}, 16'h1);
		chk("mux", {15'h0, mux}, 16'h1);
		wrr(8'h10, 8'h5a);
		wrr(8'h15, 8'h3c);
		wrr(8'h16, 8'hff);
		wrr(8'h17, 8'hff);
		rdr(8'h16, 8'h87);
		rdr(8'h17, 8'ha7);
		chk("trim", {8'h00, trim}, 16'h005a);
		chk("drive", {8'h00, drv}, 16'h003c);
		chk("fine_delay", {8'h00, fdel}, 16'h00a7);
	endtask
	task automatic t_fmt;
		for (int f = 0; f < 4; f++) begin
			wrr(8'h14, 8'(f));
			smp(16'h8001, fmt(f, 16'h8001), "fmt");
			wrr(8'h14, 8'(f) | 8'h04);
			smp(16'h7ffe, ~fmt(f, 16'h7ffe), "fmt_inv");
		end
	endtask
	task automatic t_user;
		wrr(8'h19, 8'h34);
		wrr(8'h1a, 8'h12);
		tm = 4'h8;
		repeat (6) @(posedge clk);
		#1 chk("user", od, 16'h1234);
		chk("capture", cw, 16'h1234);
		tm = 4'h0;
	endtask
	task automatic t_phase;
		logic [3:0] v[3];
		dr = 3'h3;
		for (int p = 0; p < 3; p++) begin
			wrr(8'h16, p == 2 ? 8'h83 : 8'(3 * p));
			repeat (12) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				#1 v[p][cyc % 4] = oclk;
				@(posedge clk);
			end
			#1;
		end
		chk("duty", 16'($countones(v[0])), 16'h0002);
		chk("edges", 16'($countones(v[0] ^ {v[0][2:0], v[0][3]})), 16'h0002);
		chk("phase", {12'h0, v[1]}, {12'h0, v[0][0], v[0][3:1]});
		chk("polarity", {12'h0, v[2]}, {12'h0, ~v[1]});
		wrr(8'h16, 8'h07);
		smp(16'h1234, 16'hedcb, "latency");
		dr = 3'h0;
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		{srst, wr, rd, sv, addr, wd, sd, tm, dr} = {4'h8, 8'h00, 8'h00, 16'h0000, 7'h00};
		repeat (12) @(posedge clk);
		#1 srst = 0;
		t_regs;
		t_fmt;
		t_user;
		t_phase;
		final_report;
	end
endmodule // tb
